// ==== src/memory_size_partition_defines.svh ====
`ifndef MEMORY_SIZE_PARTITION_DEFINES_SVH
`define MEMORY_SIZE_PARTITION_DEFINES_SVH

// byte addresses on the register bus
`define DATA_RAM_SIZE_ADDR   4'h0
`define USER_FLASH_BASE_ADDR 4'h4

// user flash base field position
`define UFB_FIELD_MSB 19
`define UFB_FIELD_LSB 11
`define UFB_RESET     9'h000

// data ram size codes, in bytes
`define RAM_BYTES_16K  32'h0000_4000
`define RAM_BYTES_32K  32'h0000_8000
`define RAM_BYTES_64K  32'h0001_0000
`define RAM_BYTES_128K 32'h0002_0000

`endif

// ==== src/memory_size_partition_pkg.sv ====
`default_nettype none
package memory_size_partition_pkg;
  typedef enum logic [1:0] {RAM_16K, RAM_32K, RAM_64K, RAM_128K} ram_size_e;

  typedef struct packed {
    logic        wait_req;
    logic [31:0] rdata;
    logic        kernel_only;
  } regs_state_s;

  typedef struct packed {
    logic [8:0] field;
  } base_state_s;
endpackage
`default_nettype wire

// ==== src/flash_base_if.sv ====
`default_nettype none
interface flash_base_if;
  logic        we;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] value;
  modport ctrl  (output we, output wdata, output be, input value);
  modport store (input we, input wdata, input be, output value);
endinterface
`default_nettype wire

// ==== src/flash_base_reg.sv ====
`include "memory_size_partition_defines.svh"
`default_nettype none
module flash_base_reg
  import memory_size_partition_pkg::*;
(
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  flash_base_if.store port
);
  base_state_s state_q;
  base_state_s state_d;
  logic [31:0] merged;

  // only the field is stored, so fixed bits cannot be written
  assign port.value = {12'h000, state_q.field, 11'h000};

  always_comb begin
    state_d = state_q;
    merged  = port.value;
    if (port.be[1]) begin
      merged[15:8] = port.wdata[15:8];
    end
    if (port.be[2]) begin
      merged[23:16] = port.wdata[23:16];
    end
    if (port.we) begin
      state_d.field = merged[`UFB_FIELD_MSB:`UFB_FIELD_LSB];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q.field <= `UFB_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  fixed_bits_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    port.value[31:20] == 12'h000 && port.value[10:0] == 11'h000)
    else $error("fixed bits of user flash base not zero");

  field_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    port.we && port.be == 4'hf |=> port.value[19:11] == $past(port.wdata[19:11]))
    else $error("user flash base field did not take write data");

  field_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !port.we |=> $stable(port.value))
    else $error("user flash base changed without a write");
endmodule
`default_nettype wire

// ==== src/memory_size_partition_regs.sv ====
// Functional notes
// - data ram size reads fixed byte count: 0x4000 for 16 KB, 0x8000 for 32 KB.
// - larger parts read 0x10000 for 64 KB and 0x20000 for 128 KB.
// - user flash base bits 31..20 always read zero.
// - user flash base bits 19..11 are software read/write base address.
// - user flash base bits 10..0 read zero, giving 2 KB steps.
// - reset clears user flash base, leaving all memory to kernel mode.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`include "memory_size_partition_defines.svh"
`default_nettype none
module memory_size_partition_regs
  import memory_size_partition_pkg::*;
#(
  parameter ram_size_e RAM_SIZE = RAM_128K
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  output logic [31:0]      user_flash_base_o,
  output logic             kernel_only_o
);
  localparam logic [31:0] RAM_BYTES =
    (RAM_SIZE == RAM_16K) ? `RAM_BYTES_16K :
    (RAM_SIZE == RAM_32K) ? `RAM_BYTES_32K :
    (RAM_SIZE == RAM_64K) ? `RAM_BYTES_64K : `RAM_BYTES_128K;

  regs_state_s  state_q;
  regs_state_s  state_d;
  logic         commit;
  logic         sel_size;
  logic         sel_base;
  flash_base_if base_bus ();

  flash_base_reg u_base (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .port    (base_bus)
  );

  // compare on the two index bits only, so both sides have the same width
  assign sel_size = address_i[3:2] == 2'(`DATA_RAM_SIZE_ADDR >> 2);
  assign sel_base = address_i[3:2] == 2'(`USER_FLASH_BASE_ADDR >> 2);
  // write lands on the edge where the master sees waitrequest low
  assign commit   = !state_q.wait_req && write_i;

  assign base_bus.we    = commit && sel_base;
  assign base_bus.wdata = writedata_i;
  assign base_bus.be    = byteenable_i;

  always_comb begin
    state_d             = state_q;
    state_d.kernel_only = base_bus.value == 32'h0000_0000;
    if (state_q.wait_req) begin
      if (read_i || write_i) begin
        state_d.wait_req = 1'b0;
        state_d.rdata    = 32'h0000_0000;
        if (read_i && sel_size) begin
          state_d.rdata = RAM_BYTES;
        end else if (read_i && sel_base) begin
          state_d.rdata = base_bus.value;
        end
      end
    end else begin
      // one answer per request; the master drops it after this edge
      state_d.wait_req = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q.wait_req    <= 1'b1;
      state_q.rdata       <= 32'h0000_0000;
      state_q.kernel_only <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign readdata_o        = state_q.rdata;
  assign waitrequest_o     = state_q.wait_req;
  assign user_flash_base_o = base_bus.value;
  assign kernel_only_o     = state_q.kernel_only;

  ram_size_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    read_i && !waitrequest_o && sel_size |-> readdata_o == RAM_BYTES)
    else $error("data ram size read wrong value");

  ram_size_legal_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    read_i && !waitrequest_o && sel_size |-> readdata_o inside
      {`RAM_BYTES_16K, `RAM_BYTES_32K, `RAM_BYTES_64K, `RAM_BYTES_128K})
    else $error("data ram size not a legal code");

  base_read_zero_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    read_i && !waitrequest_o && sel_base |->
      readdata_o[31:20] == 12'h000 && readdata_o[10:0] == 11'h000)
    else $error("user flash base read nonzero fixed bits");

  base_reset_a: assert property (@(posedge clock_i)
    $rose(rst_b_i) |-> user_flash_base_o == 32'h0000_0000 && kernel_only_o)
    else $error("user flash base not cleared by reset");

  size_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    commit && sel_size |=> $stable(user_flash_base_o))
    else $error("write to data ram size disturbed user flash base");

  answer_time_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not after exactly one wait cycle");

  // an idle bus leaves the slave stalling
  wait_idle_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !read_i && !write_i && waitrequest_o
    |=> waitrequest_o)
    else $error("waitrequest dropped with no request");

  // the answer stands one cycle only, so a held request is not taken twice
  wait_single_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !waitrequest_o
    |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  // reset leaves the bus stalled with no stale read data
  wait_reset_a: assert property (
    @(posedge clock_i)
    $rose(rst_b_i)
    |-> waitrequest_o && readdata_o == 32'h0000_0000)
    else $error("bus outputs not at reset values after reset");

  // read data only move together with an answer
  rdata_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $changed(readdata_o)
    |-> $fell(waitrequest_o))
    else $error("read data changed without an answer");

  // unmapped reads answer with zero rather than leftover data
  rdata_unmapped_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    read_i && !waitrequest_o && !sel_size && !sel_base
    |-> readdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  // a write answer carries no read data
  write_rdata_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o
    |-> readdata_o == 32'h0000_0000)
    else $error("write answer carried read data");

  // no write can land between the taking edge and the answer
  base_read_match_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    read_i && !waitrequest_o && sel_base
    |-> readdata_o == $past(user_flash_base_o))
    else $error("user flash base read differs from stored value");

  base_fixed_out_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    1'b1
    |-> user_flash_base_o[31:20] == 12'h000 && user_flash_base_o[10:0] == 11'h000)
    else $error("user flash base output has nonzero fixed bits");

  unmapped_write_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o && !sel_base
    |=> $stable(user_flash_base_o))
    else $error("write elsewhere disturbed user flash base");

  base_change_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    $changed(user_flash_base_o)
    |-> $past(base_bus.we))
    else $error("user flash base changed without a committed write");

  lane_one_write_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o && sel_base && byteenable_i[1]
    |=> user_flash_base_o[15:11] == $past(writedata_i[15:11]))
    else $error("user flash base bits 15 to 11 did not take write data");

  lane_two_write_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o && sel_base && byteenable_i[2]
    |=> user_flash_base_o[19:16] == $past(writedata_i[19:16]))
    else $error("user flash base bits 19 to 16 did not take write data");

  lane_one_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o && sel_base && !byteenable_i[1]
    |=> user_flash_base_o[15:11] == $past(user_flash_base_o[15:11]))
    else $error("disabled lane one changed user flash base");

  lane_two_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    write_i && !waitrequest_o && sel_base && !byteenable_i[2]
    |=> user_flash_base_o[19:16] == $past(user_flash_base_o[19:16]))
    else $error("disabled lane two changed user flash base");

  // the flag lags the base by one cycle, since it is registered
  kernel_flag_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    1'b1
    |-> kernel_only_o == ($past(user_flash_base_o) == 32'h0000_0000))
    else $error("kernel only flag does not follow user flash base");
endmodule
`default_nettype wire

// ==== tb/memory_size_partition_regs_tb.sv ====
`include "memory_size_partition_defines.svh"
`default_nettype none
module memory_size_partition_regs_tb
  import memory_size_partition_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_b_i, read_i, write_i, waitrequest_o, kernel_only_o;
  logic [3:0]  address_i, byteenable_i, be;
  logic [31:0] writedata_i, readdata_o, user_flash_base_o, rd, wd, base;
  int          failures, n_tests, seed;

  memory_size_partition_regs #(.RAM_SIZE(RAM_64K)) memory_size_partition_regs_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .user_flash_base_o(user_flash_base_o), .kernel_only_o(kernel_only_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low; bounded so a stuck slave cannot hang
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] bes);
    int n;
    n = 0;
    @(posedge clock_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= bes;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  function automatic logic [31:0] upd(input logic [31:0] b, input logic [31:0] d,
                                      input logic [3:0] bes);
    logic [31:0] r;
    r = b;
    if (bes[1]) r[15:11] = d[15:11];
    if (bes[2]) r[19:16] = d[19:16];
    return r;
  endfunction

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    repeat (5000) @(posedge clock_i);
    failures++;
    end_of_test();
  end

  initial begin
    seed = 32'hb670;
    {rst_b_i, read_i, write_i, address_i, byteenable_i, writedata_i} = '0;
    failures = 0;
    n_tests = 0;
    base = '0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    chk(user_flash_base_o, 32'h0);
    chk({31'h0, kernel_only_o}, 32'h1);
    bus(1'b0, `DATA_RAM_SIZE_ADDR, 32'h0, 4'hf);
    chk(rd, `RAM_BYTES_64K);
    bus(1'b1, `DATA_RAM_SIZE_ADDR, 32'hffff_ffff, 4'hf);
    bus(1'b0, `DATA_RAM_SIZE_ADDR, 32'h0, 4'hf);
    chk(rd, `RAM_BYTES_64K);
    $display("size test done");
    // first two passes set every bit and then clear all, the rest are random
    // the field tops out at 0xff800, inside a 1 MB program flash
    for (int i = 0; i < 40; i++) begin
      wd = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      be = (i < 2) ? 4'hf : 4'($random(seed));
      bus(1'b1, `USER_FLASH_BASE_ADDR, wd, be);
      base = upd(base, wd, be);
      bus(1'b0, `USER_FLASH_BASE_ADDR | 4'($random(seed) & 32'h3), 32'h0, 4'hf);
      chk(rd, base);
      chk(user_flash_base_o, base);
      chk({31'h0, kernel_only_o}, {31'h0, base == 32'h0});
    end
    $display("base test done");
    for (int a = 8; a < 16; a += 4) begin
      bus(1'b1, 4'(a), 32'hffff_ffff, 4'hf);
      bus(1'b0, 4'(a), 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
    bus(1'b0, `USER_FLASH_BASE_ADDR, 32'h0, 4'hf);
    chk(rd, base);
    $display("unmapped test done");
    bus(1'b1, `USER_FLASH_BASE_ADDR, 32'h000f_f800, 4'hf);
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    bus(1'b0, `USER_FLASH_BASE_ADDR, 32'h0, 4'hf);
    chk(rd, 32'h0);
    chk({31'h0, kernel_only_o}, 32'h1);
    $display("reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
